// ==== core/oprr_regs.svh ====
`ifndef OPRR_REGS_SVH
`define OPRR_REGS_SVH

// register indices; byte address is four times the index
`define OPRR_IDX_QUADRANT 8'h53
`define OPRR_IDX_TRIM 8'h55
`define OPRR_IDX_BAL_CTRL 8'h60
`define OPRR_IDX_BAL_RATE 8'h61
`define OPRR_IDX_REF_MODE 8'h65
`define OPRR_IDX_MULT_LOW 8'h67
`define OPRR_IDX_MULT_HIGH 8'h68
`define OPRR_IDX_BAND 8'h70

// reset values
`define OPRR_RST_QUADRANT 8'h00
`define OPRR_RST_TRIM 8'h00
`define OPRR_RST_BAL_CTRL 8'ha3
`define OPRR_RST_BAL_RATE 8'h55
`define OPRR_RST_REF_MODE 8'h00
`define OPRR_RST_MULT_LOW 8'h00
`define OPRR_RST_MULT_HIGH 8'h00
`define OPRR_RST_BAND 8'h00

// field positions
`define OPRR_QUAD_MSB 1
`define OPRR_QUAD_LSB 0
`define OPRR_BAL_EN_BIT 1
`define OPRR_SKEW_MSB 7
`define OPRR_SKEW_LSB 6
`define OPRR_RATE_MSB 6
`define OPRR_RATE_LSB 4
`define OPRR_MODE_MSB 1
`define OPRR_MODE_LSB 0
`define OPRR_MULT_HIGH_MSB 5
`define OPRR_BAND_BIT 5

// step sizes: trim in tenths of ps, skew in ps, rate unit in kHz
`define OPRR_TRIM_STEP_TENTH_PS 1192
`define OPRR_SKEW_STEP_PS 1600
`define OPRR_QUAD_STEP_DEG 90
`define OPRR_RATE_UNIT_KHZ 8

`endif

// ==== core/oprr_pkg.sv ====
package oprr_pkg;

    typedef enum logic [1:0] {
        OPRR_REF_AUTO = 2'h0,
        OPRR_REF_USER_A = 2'h1,
        OPRR_REF_USER_B = 2'h2,
        OPRR_REF_RESERVED = 2'h3
    } oprr_ref_mode_t;

    typedef enum logic [3:0] {
        OPRR_SEL_NONE = 4'h0,
        OPRR_SEL_QUADRANT = 4'h1,
        OPRR_SEL_TRIM = 4'h2,
        OPRR_SEL_BAL_CTRL = 4'h3,
        OPRR_SEL_BAL_RATE = 4'h4,
        OPRR_SEL_REF_MODE = 4'h5,
        OPRR_SEL_MULT_LOW = 4'h6,
        OPRR_SEL_MULT_HIGH = 4'h7,
        OPRR_SEL_BAND = 4'h8
    } oprr_sel_t;

endpackage : oprr_pkg

// ==== core/oprr_output_phase_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "oprr_regs.svh"

module oprr_output_phase_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [1:0] coarse_phase_quadrant,
    output logic [8:0] coarse_phase_deg,
    output logic signed [7:0] fine_phase_trim,
    output logic signed [18:0] fine_phase_tenth_ps,
    output logic balanced_clk_oe_n,
    output logic [1:0] balanced_skew,
    output logic [12:0] balanced_skew_ps,
    output logic [2:0] balanced_rate_code,
    output logic balanced_low_band,
    output oprr_pkg::oprr_ref_mode_t ref_rate_mode,
    output logic ref_mode_reserved,
    output logic [13:0] user_rate_a_multiple,
    output logic [16:0] user_rate_a_khz
);

    if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_w_check
        $error("ADDR_W must lie between 10 and 32");
    end

    // map a byte address to a register; misaligned words are unmapped
    function automatic oprr_pkg::oprr_sel_t decode(
        input logic [ADDR_W-1:0] addr
    );
        logic [ADDR_W-3:0] idx;
        idx = addr[ADDR_W-1:2];
        decode = oprr_pkg::OPRR_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            if (idx == (ADDR_W-2)'(`OPRR_IDX_QUADRANT)) begin
                decode = oprr_pkg::OPRR_SEL_QUADRANT;
            end else if (idx == (ADDR_W-2)'(`OPRR_IDX_TRIM)) begin
                decode = oprr_pkg::OPRR_SEL_TRIM;
            end else if (idx == (ADDR_W-2)'(`OPRR_IDX_BAL_CTRL)) begin
                decode = oprr_pkg::OPRR_SEL_BAL_CTRL;
            end else if (idx == (ADDR_W-2)'(`OPRR_IDX_BAL_RATE)) begin
                decode = oprr_pkg::OPRR_SEL_BAL_RATE;
            end else if (idx == (ADDR_W-2)'(`OPRR_IDX_REF_MODE)) begin
                decode = oprr_pkg::OPRR_SEL_REF_MODE;
            end else if (idx == (ADDR_W-2)'(`OPRR_IDX_MULT_LOW)) begin
                decode = oprr_pkg::OPRR_SEL_MULT_LOW;
            end else if (idx == (ADDR_W-2)'(`OPRR_IDX_MULT_HIGH)) begin
                decode = oprr_pkg::OPRR_SEL_MULT_HIGH;
            end else if (idx == (ADDR_W-2)'(`OPRR_IDX_BAND)) begin
                decode = oprr_pkg::OPRR_SEL_BAND;
            end
        end
    endfunction : decode

    oprr_pkg::oprr_sel_t sel;
    logic setup_phase;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] quadrant_reg;
    logic [7:0] trim_reg;
    logic [7:0] bal_ctrl_reg;
    logic [7:0] bal_rate_reg;
    logic [7:0] ref_mode_reg;
    logic [7:0] mult_low_reg;
    logic [7:0] mult_high_reg;
    logic [7:0] band_reg;
    logic [7:0] rdata_next;
    logic [13:0] mult_next;

    assign sel = decode(paddr);
    assign setup_phase = psel && !penable;
    // writes land only at the access edge the master samples pready
    assign wr_en = psel && penable && pready && pwrite;
    assign wbyte = pwdata[7:0];
    assign mult_next = {mult_high_reg[`OPRR_MULT_HIGH_MSB:0], mult_low_reg};

    // zero wait states: pready rises for the access cycle after each setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_phase && (sel == oprr_pkg::OPRR_SEL_NONE);
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        unique case (sel)
            oprr_pkg::OPRR_SEL_QUADRANT: rdata_next = quadrant_reg;
            oprr_pkg::OPRR_SEL_TRIM: rdata_next = trim_reg;
            oprr_pkg::OPRR_SEL_BAL_CTRL: rdata_next = bal_ctrl_reg;
            oprr_pkg::OPRR_SEL_BAL_RATE: rdata_next = bal_rate_reg;
            oprr_pkg::OPRR_SEL_REF_MODE: rdata_next = ref_mode_reg;
            oprr_pkg::OPRR_SEL_MULT_LOW: rdata_next = mult_low_reg;
            oprr_pkg::OPRR_SEL_MULT_HIGH: rdata_next = mult_high_reg;
            oprr_pkg::OPRR_SEL_BAND: rdata_next = band_reg;
            oprr_pkg::OPRR_SEL_NONE: rdata_next = 8'h00;
        endcase
    end

    // read data is captured at setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= {24'h00_0000, rdata_next};
        end
    end

    // whole bytes are kept so reserved bits read back as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quadrant_reg <= `OPRR_RST_QUADRANT;
            trim_reg <= `OPRR_RST_TRIM;
        end else if (wr_en) begin
            if (sel == oprr_pkg::OPRR_SEL_QUADRANT) begin
                quadrant_reg <= wbyte;
            end
            if (sel == oprr_pkg::OPRR_SEL_TRIM) begin
                trim_reg <= wbyte;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bal_ctrl_reg <= `OPRR_RST_BAL_CTRL;
            bal_rate_reg <= `OPRR_RST_BAL_RATE;
            band_reg <= `OPRR_RST_BAND;
        end else if (wr_en) begin
            if (sel == oprr_pkg::OPRR_SEL_BAL_CTRL) begin
                bal_ctrl_reg <= wbyte;
            end
            if (sel == oprr_pkg::OPRR_SEL_BAL_RATE) begin
                bal_rate_reg <= wbyte;
            end
            if (sel == oprr_pkg::OPRR_SEL_BAND) begin
                band_reg <= wbyte;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_mode_reg <= `OPRR_RST_REF_MODE;
            mult_low_reg <= `OPRR_RST_MULT_LOW;
            mult_high_reg <= `OPRR_RST_MULT_HIGH;
        end else if (wr_en) begin
            if (sel == oprr_pkg::OPRR_SEL_REF_MODE) begin
                ref_mode_reg <= wbyte;
            end
            if (sel == oprr_pkg::OPRR_SEL_MULT_LOW) begin
                mult_low_reg <= wbyte;
            end
            if (sel == oprr_pkg::OPRR_SEL_MULT_HIGH) begin
                mult_high_reg <= wbyte;
            end
        end
    end

    // field outputs follow the stored bytes one edge later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_phase_quadrant <= 2'h0;
            coarse_phase_deg <= 9'h000;
        end else begin
            coarse_phase_quadrant <=
                quadrant_reg[`OPRR_QUAD_MSB:`OPRR_QUAD_LSB];
            coarse_phase_deg <= 9'(quadrant_reg[`OPRR_QUAD_MSB:`OPRR_QUAD_LSB]
                * `OPRR_QUAD_STEP_DEG);
        end
    end

    // signed product keeps negative trims as advances
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_phase_trim <= 8'sh00;
            fine_phase_tenth_ps <= 19'sh0_0000;
        end else begin
            fine_phase_trim <= $signed(trim_reg);
            fine_phase_tenth_ps <= 19'($signed(trim_reg)
                * $signed(12'(`OPRR_TRIM_STEP_TENTH_PS)));
        end
    end

    // oe_n held high under reset keeps the pair released until defaults load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            balanced_clk_oe_n <= 1'b1;
            balanced_skew <= 2'h0;
            balanced_skew_ps <= 13'h0000;
        end else begin
            balanced_clk_oe_n <= !bal_ctrl_reg[`OPRR_BAL_EN_BIT];
            balanced_skew <=
                bal_ctrl_reg[`OPRR_SKEW_MSB:`OPRR_SKEW_LSB];
            balanced_skew_ps <= 13'(bal_ctrl_reg[`OPRR_SKEW_MSB:`OPRR_SKEW_LSB]
                * `OPRR_SKEW_STEP_PS);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            balanced_rate_code <= 3'h0;
            balanced_low_band <= 1'b0;
        end else begin
            balanced_rate_code <=
                bal_rate_reg[`OPRR_RATE_MSB:`OPRR_RATE_LSB];
            balanced_low_band <= band_reg[`OPRR_BAND_BIT];
        end
    end

    // reserved mode code is passed on but flagged for the monitor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_rate_mode <= oprr_pkg::OPRR_REF_AUTO;
            ref_mode_reserved <= 1'b0;
        end else begin
            ref_rate_mode <= oprr_pkg::oprr_ref_mode_t'(
                ref_mode_reg[`OPRR_MODE_MSB:`OPRR_MODE_LSB]);
            ref_mode_reserved <= ref_mode_reg[`OPRR_MODE_MSB:`OPRR_MODE_LSB]
                == oprr_pkg::OPRR_REF_RESERVED;
        end
    end

    // halves are not write-locked; software writes low then high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_rate_a_multiple <= 14'h0000;
            user_rate_a_khz <= 17'h0_0000;
        end else begin
            user_rate_a_multiple <= mult_next;
            user_rate_a_khz <= 17'(mult_next * `OPRR_RATE_UNIT_KHZ);
        end
    end

    logic after_reset_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            after_reset_reg <= 1'b0;
        end else begin
            after_reset_reg <= 1'b1;
        end
    end

    property p_quadrant;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_QUADRANT) |=> ##1
        (coarse_phase_quadrant == $past(pwdata[1:0], 2)
        && coarse_phase_deg == 9'($past(pwdata[1:0], 2) * 90));
    endproperty
    a_quadrant: assert property (p_quadrant)
        else $error("coarse quadrant did not follow write");

    property p_trim;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_TRIM) |=> ##1
        (fine_phase_tenth_ps ==
        19'($signed($past(pwdata[7:0], 2)) * $signed(12'h4a8)));
    endproperty
    a_trim: assert property (p_trim)
        else $error("fine trim scaling wrong");

    property p_enable;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_BAL_CTRL) |=> ##1
        (balanced_clk_oe_n == !$past(pwdata[1], 2));
    endproperty
    a_enable: assert property (p_enable)
        else $error("balanced output enable wrong");

    property p_skew;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_BAL_CTRL) |=> ##1
        (balanced_skew_ps == 13'($past(pwdata[7:6], 2) * 1600));
    endproperty
    a_skew: assert property (p_skew)
        else $error("skew step wrong");

    property p_skew_reset;
        @(posedge pclk) disable iff (!presetn)
        !after_reset_reg |-> bal_ctrl_reg == 8'ha3 ##1 balanced_skew == 2'h2;
    endproperty
    a_skew_reset: assert property (p_skew_reset)
        else $error("skew reset value wrong");

    property p_rate;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_BAL_RATE) |=> ##1
        (balanced_rate_code == $past(pwdata[6:4], 2));
    endproperty
    a_rate: assert property (p_rate)
        else $error("rate code did not follow write");

    property p_mode;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_REF_MODE) |=> ##1
        (ref_rate_mode == $past(pwdata[1:0], 2)
        && ref_mode_reserved == ($past(pwdata[1:0], 2) == 2'h3));
    endproperty
    a_mode: assert property (p_mode)
        else $error("reference mode wrong");

    property p_mult_low;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_MULT_LOW) |=> ##1
        (user_rate_a_multiple[7:0] == $past(pwdata[7:0], 2)
        && user_rate_a_khz == 17'(user_rate_a_multiple * 8));
    endproperty
    a_mult_low: assert property (p_mult_low)
        else $error("low multiplier wrong");

    property p_mult_high;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_MULT_HIGH) |=> ##1
        (user_rate_a_multiple[13:8] == $past(pwdata[5:0], 2));
    endproperty
    a_mult_high: assert property (p_mult_high)
        else $error("high multiplier wrong");

    property p_band;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_BAND) |=> ##1
        (balanced_low_band == $past(pwdata[5], 2));
    endproperty
    a_band: assert property (p_band)
        else $error("band select wrong");

    property p_readback;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel == oprr_pkg::OPRR_SEL_QUADRANT) ##1
        (setup_phase && !pwrite && sel == oprr_pkg::OPRR_SEL_QUADRANT)
        |=> prdata == {24'h0, $past(pwdata[7:0], 2)};
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback differs from write");

endmodule : oprr_output_phase_regs
`default_nettype wire

// ==== verification/tb_output_phase_and_ref_rate_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "oprr_regs.svh"

module tb_output_phase_and_ref_rate_regs;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] quad;
    logic [8:0] deg;
    logic signed [7:0] trim;
    logic signed [18:0] trim_tps;
    logic oe_n;
    logic [1:0] skew;
    logic [12:0] skew_ps;
    logic [2:0] rate;
    logic low_band;
    oprr_pkg::oprr_ref_mode_t mode;
    logic mode_rsv;
    logic [13:0] mult;
    logic [16:0] mult_khz;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int n_compared = 0;
    localparam logic [7:0] IDX [8] = '{`OPRR_IDX_QUADRANT, `OPRR_IDX_TRIM,
        `OPRR_IDX_BAL_CTRL, `OPRR_IDX_BAL_RATE, `OPRR_IDX_REF_MODE,
        `OPRR_IDX_MULT_LOW, `OPRR_IDX_MULT_HIGH, `OPRR_IDX_BAND};
    localparam logic [7:0] RST [8] = '{`OPRR_RST_QUADRANT, `OPRR_RST_TRIM,
        `OPRR_RST_BAL_CTRL, `OPRR_RST_BAL_RATE, `OPRR_RST_REF_MODE,
        `OPRR_RST_MULT_LOW, `OPRR_RST_MULT_HIGH, `OPRR_RST_BAND};
    localparam logic [7:0] TRIMS [5] = '{8'h00, 8'h7f, 8'h80, 8'hff, 8'h01};

    always #2.5 pclk = ~pclk;

    oprr_output_phase_regs #(.ADDR_W(12)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .coarse_phase_quadrant(quad), .coarse_phase_deg(deg),
        .fine_phase_trim(trim), .fine_phase_tenth_ps(trim_tps),
        .balanced_clk_oe_n(oe_n), .balanced_skew(skew),
        .balanced_skew_ps(skew_ps), .balanced_rate_code(rate),
        .balanced_low_band(low_band), .ref_rate_mode(mode),
        .ref_mode_reserved(mode_rsv), .user_rate_a_multiple(mult),
        .user_rate_a_khz(mult_khz)
    );

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ba

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // caller stands just after a rising edge; no release here so that a
    // following call can put its setup on the sampling edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("ERROR pready expected 1 seen timeout");
        end
        rd = prdata;
        err = pslverr;
    endtask : apb

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        apb(w, a, d);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // field outputs follow the stored byte one edge later
    task automatic settle();
        @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        xfer(1'b1, ba(idx), d);
        settle();
    endtask : wr

    task automatic rdchk(input string name, input logic [7:0] idx,
                         input logic [31:0] exp);
        xfer(1'b0, ba(idx), 32'h0);
        chk(name, rd, exp);
        chk({name, "_slverr"}, 32'(err), 32'h0);
    endtask : rdchk

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge pclk);
        chk("oe_n_in_reset", 32'(oe_n), 32'h1);
        presetn <= 1'b1;
        settle();
        chk("oe_n_reset", 32'(oe_n), 32'h0);
        chk("skew_reset", 32'(skew), 32'h2);
        chk("skew_ps_reset", 32'(skew_ps), 32'h0000_0c80);
        chk("rate_reset", 32'(rate), 32'h5);
        for (int i = 0; i < 8; i++) begin
            rdchk("reset_value", IDX[i], 32'(RST[i]));
        end
        $display("test reset done");
        for (int q = 0; q < 4; q++) begin
            wr(`OPRR_IDX_QUADRANT, 32'(q));
            chk("quadrant", 32'(quad), 32'(q));
            chk("quadrant_deg", 32'(deg), 32'(q * 90));
            rdchk("quadrant_rb", `OPRR_IDX_QUADRANT, 32'(q));
        end
        $display("test quadrant done");
        for (int i = 0; i < 5; i++) begin
            wr(`OPRR_IDX_TRIM, 32'(TRIMS[i]));
            chk("trim", 32'(trim), 32'($signed(TRIMS[i])));
            chk("trim_tps", 32'(trim_tps),
                32'($signed(TRIMS[i]) * 1192));
        end
        $display("test trim done");
        for (int i = 0; i < 8; i++) begin
            wr(`OPRR_IDX_BAL_CTRL,
               {24'h0, 2'(i), 4'h8, i >= 4, 1'b1});
            chk("oe_n", 32'(oe_n), 32'(i < 4));
            chk("skew", 32'(skew), 32'(i % 4));
            chk("skew_ps", 32'(skew_ps), 32'((i % 4) * 1600));
        end
        $display("test balanced control done");
        for (int c = 0; c < 8; c++) begin
            wr(`OPRR_IDX_BAL_RATE, {24'h0, 1'b0, 3'(c), 4'h5});
            chk("rate", 32'(rate), 32'(c));
        end
        for (int b = 1; b >= 0; b--) begin
            wr(`OPRR_IDX_BAND, 32'(b) << 5);
            chk("low_band", 32'(low_band), 32'(b));
        end
        $display("test rate done");
        for (int m = 0; m < 4; m++) begin
            wr(`OPRR_IDX_REF_MODE, 32'(m));
            chk("ref_mode", 32'(mode), 32'(m));
            chk("ref_mode_rsv", 32'(mode_rsv), 32'(m == 3));
        end
        $display("test reference mode done");
        // back to back: second setup sits on the first sampling edge
        @(posedge pclk);
        apb(1'b1, ba(`OPRR_IDX_MULT_LOW), 32'hffffff5a);
        apb(1'b1, ba(`OPRR_IDX_MULT_HIGH), 32'h0000003f);
        apb(1'b1, ba(`OPRR_IDX_QUADRANT), 32'h00000001);
        apb(1'b0, ba(`OPRR_IDX_QUADRANT), 32'h0);
        chk("quadrant_b2b_rb", rd, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        settle();
        chk("mult", 32'(mult), 32'h3f5a);
        chk("mult_khz", 32'(mult_khz), 32'h3f5a * 8);
        rdchk("mult_low_rb", `OPRR_IDX_MULT_LOW, 32'h5a);
        wr(`OPRR_IDX_MULT_LOW, 32'h01);
        chk("mult_low_only", 32'(mult), 32'h3f01);
        chk("mult_khz_low", 32'(mult_khz), 32'h3f01 * 8);
        $display("test multiplier done");
        xfer(1'b1, ba(`OPRR_IDX_QUADRANT) + 12'h1, 32'h0);
        chk("misaligned_slverr", 32'(err), 32'h1);
        xfer(1'b0, 12'h150, 32'h0);
        chk("unmapped_slverr", 32'(err), 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        settle();
        chk("quadrant_kept", 32'(quad), 32'h1);
        $display("test refused access done");
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk("oe_n_rereset", 32'(oe_n), 32'h1);
        @(posedge pclk);
        presetn <= 1'b1;
        settle();
        rdchk("bal_ctrl_rereset", `OPRR_IDX_BAL_CTRL, 32'ha3);
        chk("skew_rereset", 32'(skew), 32'h2);
        chk("rate_rereset", 32'(rate), 32'h5);
        $display("test second reset done");
        complete_run();
    end
endmodule : tb_output_phase_and_ref_rate_regs
`default_nettype wire
